//--- shared/dwd_pkg.sv
// shared constants, field layout and command codes of the dual wiper command decoder
package dwd_pkg;
  localparam int FRAME_BITS = 24;
  localparam int CNT_W = 5;
  localparam int CMD_HI = 23;
  localparam int CMD_LO = 20;
  localparam int ADDR_HI = 19;
  localparam int ADDR_LO = 16;
  localparam int DATA_HI = 15;
  localparam int DATA_LO = 0;
  localparam int WIPER_BITS = 10;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int NV_DEPTH = 16;
  localparam int CHANNELS = 2;
  // bit count at which the two data bytes start on the serial output
  localparam int READBACK_FIRST = 8;
  localparam logic [3:0] NV_READ_ONLY = 4'hf;
  localparam logic [3:0] ADDR_ZERO = 4'h0;
  localparam logic [15:0] NV_WIPER_INIT = 16'h0200;

  typedef enum logic [3:0] {
    cmd_nop = 4'h0,
    cmd_restore = 4'h1,
    cmd_store = 4'h2,
    cmd_write_nv = 4'h3,
    cmd_shr_one = 4'h4,
    cmd_shr_all = 4'h5,
    cmd_dec_one = 4'h6,
    cmd_dec_all = 4'h7,
    cmd_reload_all = 4'h8,
    cmd_read_nv = 4'h9,
    cmd_read_wiper = 4'ha,
    cmd_write_wiper = 4'hb,
    cmd_shl_one = 4'hc,
    cmd_shl_all = 4'hd,
    cmd_inc_one = 4'he,
    cmd_inc_all = 4'hf
  } dwd_cmd_e;
endpackage : dwd_pkg

//--- hdl/dwd_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module dwd_sync #(
  parameter int WIDTH = 1,
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= {WIDTH{INIT}};
      sync_out <= {WIDTH{INIT}};
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : dwd_sync

//--- hdl/dwd_spi_link.sv
// serial link side: input shift register, bit counter and serial output
`timescale 1ns/1ps
module dwd_spi_link (
  input wire logic link_clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic serial_in,
  input wire logic rb_active,
  input wire logic [dwd_pkg::DATA_W-1:0] rb_data,
  output logic [dwd_pkg::FRAME_BITS-1:0] frame_word,
  output logic [dwd_pkg::CNT_W-1:0] bit_count,
  output logic frame_toggle,
  output logic serial_out,
  output logic serial_out_oe_n
);
  logic fresh;
  logic first_word;
  logic rb_seen;
  logic override;
  logic [dwd_pkg::CNT_W-1:0] rd_idx;

  // marks the first edge of a frame; the link clock is idle while chip select is high
  // reset also arms it, so the first frame after power-on toggles the frame flag
  always_ff @(posedge link_clk or posedge cs_n or negedge reset_n) begin
    if (!reset_n) begin
      fresh <= 1'b1;
    end else if (cs_n) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // sampling on the rising edge serves both clock modes
  always_ff @(posedge link_clk or negedge reset_n) begin // RULE25
    if (!reset_n) begin
      frame_word <= '0;
      bit_count <= '0;
      first_word <= 1'b0;
      frame_toggle <= 1'b0;
    end else begin
      frame_word <= {frame_word[dwd_pkg::FRAME_BITS-2:0], serial_in}; // RULE1
      if (fresh) begin
        bit_count <= dwd_pkg::CNT_W'(1);
        first_word <= 1'b1;
        frame_toggle <= ~frame_toggle;
      end else if (bit_count == dwd_pkg::CNT_W'(dwd_pkg::FRAME_BITS - 1)) begin // RULE24
        bit_count <= '0;
        first_word <= 1'b0;
      end else begin
        bit_count <= bit_count + 1'b1;
      end
    end
  end

  // read-back flag is settled long before the data bytes start
  dwd_sync #(.WIDTH(1), .INIT(1'b0)) u_rb_sync (
    .clk(link_clk),
    .rst_n(1'b1),
    .async_in(rb_active),
    .sync_out(rb_seen)
  );

  assign rd_idx = dwd_pkg::CNT_W'(dwd_pkg::FRAME_BITS - 1) - bit_count;
  assign override = rb_seen && !fresh && first_word && (bit_count >= dwd_pkg::CNT_W'(dwd_pkg::READBACK_FIRST)); // RULE17
  // previous frame's bits fall out of the top of the shift register
  assign serial_out = override ? rb_data[rd_idx[3:0]] : frame_word[dwd_pkg::FRAME_BITS-1]; // RULE16
  // open drain: only pulls low while selected
  assign serial_out_oe_n = cs_n | serial_out;
endmodule : dwd_spi_link

//--- hdl/dwd_decoder.sv
// dual wiper serial command decoder: frame capture, command execution and stores
// How it works
// [RULE1] frames arrive msb first: command 23..20, address 19..16, data 15..0
// [RULE2] wiper commands use address bit 0 and data bits 9..0 only
// [RULE3] command 0 changes no wiper or store register; it ends read power
// [RULE4] command 1 restores selected wiper from store, read power until command 0
// [RULE5] command 2 copies selected wiper into its store location
// [RULE6] command 3 writes sixteen data bits to the addressed store location, except read-only location 15
// [RULE7] store locations 0 and 1 use only their ten low bits as position
// [RULE8] commands 4 and 5 shift one or both wipers right, floor zero
// [RULE9] commands 6 and 7 decrement one or both wipers, saturating at zero
// [RULE10] command 8 with zero address reloads both wipers from the store
// [RULE11] command 9 reads the addressed store location out in the next frame
// [RULE12] command 10 reads the selected wiper out in the next frame
// [RULE13] command 11 loads ten data bits into the selected wiper
// [RULE14] commands 12 and 13 shift one or both wipers left, ceiling all ones
// [RULE15] commands 14 and 15 increment one or both wipers, saturating at all ones
// [RULE16] serial output echoes the last 24 bits received in the previous frame
// [RULE17] after a read, the two data bytes carry the selected value
// [RULE18] the controller follows a read with a full 24-bit frame
// [RULE19] at power-on each wiper loads from its store location
// [RULE20] commands execute only when chip select returns high
// [RULE21] step and shift commands ignore the data bytes
// [RULE22] left shift of zero gives one
// [RULE23] left shift at or above midscale gives full scale
// [RULE24] bits are counted in 24-bit frames; other counts are dropped
// [RULE25] link works in clock modes 0,0 and 1,1
`timescale 1ns/1ps
module dwd_decoder #(
  parameter int WIPER_W = dwd_pkg::WIPER_BITS,
  // arbitrary factory content of the user and read-only locations
  parameter logic [dwd_pkg::DATA_W-1:0] NV_USER_INIT = 16'h0000,
  parameter logic [dwd_pkg::DATA_W-1:0] NV_TOLERANCE = 16'h0000
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe_n,
  output logic [WIPER_W-1:0] wiper_ch1,
  output logic [WIPER_W-1:0] wiper_ch2,
  output logic read_power_state,
  output logic cmd_done
);
  localparam logic [WIPER_W-1:0] W_FULL = '1;
  localparam logic [WIPER_W-1:0] W_ONE = WIPER_W'(1);
  localparam logic [WIPER_W-1:0] W_MID = {1'b1, {(WIPER_W - 1){1'b0}}};
  localparam int PAD_W = dwd_pkg::DATA_W - WIPER_W;

  initial begin
    if (WIPER_W < 2 || WIPER_W > dwd_pkg::DATA_W) begin
      $error("wiper width must lie between 2 and the store width");
    end
  end

  typedef enum logic [0:0] {
    st_load = 1'b0,
    st_idle = 1'b1
  } dwd_state_e;

  dwd_state_e state;
  logic [WIPER_W-1:0] wiper [dwd_pkg::CHANNELS];
  logic [WIPER_W-1:0] next_wiper [dwd_pkg::CHANNELS];
  logic [WIPER_W-1:0] nv_pos [dwd_pkg::CHANNELS];
  logic [dwd_pkg::DATA_W-1:0] nv [dwd_pkg::NV_DEPTH];
  logic [dwd_pkg::FRAME_BITS-1:0] frame_word;
  logic [dwd_pkg::FRAME_BITS-1:0] last_word;
  logic [dwd_pkg::FRAME_BITS-1:0] exec_word;
  logic [dwd_pkg::CNT_W-1:0] bit_count;
  logic frame_toggle;
  logic tg_s;
  logic tg_seen;
  logic cs_s;
  logic cs_prev;
  logic have_last;
  logic frame_end;
  logic new_frame;
  logic frame_ok;
  logic exec;
  logic rb_active;
  logic [dwd_pkg::DATA_W-1:0] rb_data;
  dwd_pkg::dwd_cmd_e cmd;
  logic [dwd_pkg::ADDR_W-1:0] exec_addr;
  logic [dwd_pkg::DATA_W-1:0] exec_data;
  logic exec_ch;
  logic [WIPER_W-1:0] sel_wiper;
  logic [WIPER_W-1:0] sel_nv_pos;

  dwd_spi_link u_link (
    .link_clk(link_clk),
    .reset_n(reset_n),
    .cs_n(cs_n),
    .serial_in(serial_in),
    .rb_active(rb_active),
    .rb_data(rb_data),
    .frame_word(frame_word),
    .bit_count(bit_count),
    .frame_toggle(frame_toggle),
    .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n)
  );

  dwd_sync #(.WIDTH(1), .INIT(1'b1)) u_cs_sync (
    .clk(sys_clk),
    .rst_n(reset_n),
    .async_in(cs_n),
    .sync_out(cs_s)
  );

  dwd_sync #(.WIDTH(1), .INIT(1'b0)) u_tg_sync (
    .clk(sys_clk),
    .rst_n(reset_n),
    .async_in(frame_toggle),
    .sync_out(tg_s)
  );

  // step and shift arithmetic shared by single and ganged commands
  function automatic logic [WIPER_W-1:0] wiper_step(dwd_pkg::dwd_cmd_e c, logic [WIPER_W-1:0] v);
    logic [WIPER_W-1:0] r;
    r = v;
    case (c)
      dwd_pkg::cmd_shr_one, dwd_pkg::cmd_shr_all: r = v >> 1; // RULE8
      dwd_pkg::cmd_dec_one, dwd_pkg::cmd_dec_all: r = (v == '0) ? v : v - W_ONE; // RULE9
      dwd_pkg::cmd_shl_one, dwd_pkg::cmd_shl_all: begin
        if (v == '0) begin
          r = W_ONE; // RULE22
        end else if (v >= W_MID) begin
          r = W_FULL; // RULE23
        end else begin
          r = v << 1; // RULE14
        end
      end
      dwd_pkg::cmd_inc_one, dwd_pkg::cmd_inc_all: r = (v == W_FULL) ? v : v + W_ONE; // RULE15
      default: r = v;
    endcase
    return r;
  endfunction : wiper_step

  // frame end seen in this domain; link data is static while chip select is high
  assign frame_end = cs_s && !cs_prev; // RULE20
  assign new_frame = tg_s != tg_seen;
  assign frame_ok = new_frame && (bit_count == '0); // RULE24
  // a chip select strobe without clocks repeats the previous command
  assign exec = frame_end && (state == st_idle) && (frame_ok || (!new_frame && have_last));
  assign exec_word = new_frame ? frame_word : last_word;
  assign cmd = dwd_pkg::dwd_cmd_e'(exec_word[dwd_pkg::CMD_HI:dwd_pkg::CMD_LO]); // RULE1
  assign exec_addr = exec_word[dwd_pkg::ADDR_HI:dwd_pkg::ADDR_LO];
  assign exec_data = exec_word[dwd_pkg::DATA_HI:dwd_pkg::DATA_LO];
  assign exec_ch = exec_addr[0]; // RULE2
  assign sel_wiper = wiper[exec_ch];

  always_comb begin
    for (int i = 0; i < dwd_pkg::CHANNELS; i++) begin
      nv_pos[i] = nv[i][WIPER_W-1:0]; // RULE7
    end
  end
  assign sel_nv_pos = nv_pos[exec_ch];

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cs_prev <= 1'b1;
      tg_seen <= 1'b0;
    end else begin
      cs_prev <= cs_s;
      if (frame_end) begin
        tg_seen <= tg_s;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      last_word <= '0;
      have_last <= 1'b0;
    end else if (exec) begin
      last_word <= exec_word;
      have_last <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= st_load;
    end else begin
      unique case (state)
        st_load: state <= st_idle;
        st_idle: state <= st_idle;
      endcase
    end
  end

  always_comb begin
    for (int i = 0; i < dwd_pkg::CHANNELS; i++) begin
      next_wiper[i] = wiper[i];
      if (exec) begin
        unique case (cmd)
          dwd_pkg::cmd_restore: begin
            if (exec_ch == 1'(i)) begin
              next_wiper[i] = nv_pos[i]; // RULE4
            end
          end
          dwd_pkg::cmd_reload_all: begin
            if (exec_addr == dwd_pkg::ADDR_ZERO) begin
              next_wiper[i] = nv_pos[i]; // RULE10
            end
          end
          dwd_pkg::cmd_write_wiper: begin
            if (exec_ch == 1'(i)) begin
              next_wiper[i] = exec_data[WIPER_W-1:0]; // RULE13
            end
          end
          dwd_pkg::cmd_shr_one, dwd_pkg::cmd_dec_one, dwd_pkg::cmd_shl_one, dwd_pkg::cmd_inc_one: begin
            if (exec_ch == 1'(i)) begin
              next_wiper[i] = wiper_step(cmd, wiper[i]); // RULE21
            end
          end
          dwd_pkg::cmd_shr_all, dwd_pkg::cmd_dec_all, dwd_pkg::cmd_shl_all, dwd_pkg::cmd_inc_all: begin
            next_wiper[i] = wiper_step(cmd, wiper[i]); // RULE21
          end
          dwd_pkg::cmd_nop, dwd_pkg::cmd_store, dwd_pkg::cmd_write_nv,
          dwd_pkg::cmd_read_nv, dwd_pkg::cmd_read_wiper: begin
            next_wiper[i] = wiper[i]; // RULE3
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < dwd_pkg::CHANNELS; i++) begin
        wiper[i] <= '0;
      end
    end else if (state == st_load) begin
      for (int i = 0; i < dwd_pkg::CHANNELS; i++) begin
        wiper[i] <= nv_pos[i]; // RULE19
      end
    end else begin
      for (int i = 0; i < dwd_pkg::CHANNELS; i++) begin
        wiper[i] <= next_wiper[i];
      end
    end
  end

  // reset stands for power-on: stores come up with their factory content
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < dwd_pkg::NV_DEPTH; i++) begin
        nv[i] <= (i < dwd_pkg::CHANNELS) ? dwd_pkg::NV_WIPER_INIT : NV_USER_INIT;
      end
      nv[dwd_pkg::NV_READ_ONLY] <= NV_TOLERANCE;
    end else if (exec) begin
      if (cmd == dwd_pkg::cmd_store) begin
        nv[exec_ch] <= {{PAD_W{1'b0}}, sel_wiper}; // RULE5
      end else if (cmd == dwd_pkg::cmd_write_nv && exec_addr != dwd_pkg::NV_READ_ONLY) begin
        nv[exec_addr] <= exec_data; // RULE6
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      read_power_state <= 1'b0;
    end else if (exec && cmd == dwd_pkg::cmd_restore) begin
      read_power_state <= 1'b1; // RULE4
    end else if (exec && cmd == dwd_pkg::cmd_nop) begin
      read_power_state <= 1'b0;
    end
  end

  // read-back value stays put for the whole of the following frame
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rb_active <= 1'b0;
      rb_data <= '0;
    end else if (frame_end) begin
      if (exec && cmd == dwd_pkg::cmd_read_nv) begin
        rb_active <= 1'b1;
        rb_data <= nv[exec_addr]; // RULE11
      end else if (exec && cmd == dwd_pkg::cmd_read_wiper) begin
        rb_active <= 1'b1;
        rb_data <= {{PAD_W{1'b0}}, sel_wiper}; // RULE12
      end else begin
        rb_active <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cmd_done <= 1'b0;
    end else begin
      cmd_done <= exec;
    end
  end

  assign wiper_ch1 = wiper[0];
  assign wiper_ch2 = wiper[1];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_restore;
    exec && cmd == dwd_pkg::cmd_restore;
  endsequence

  sequence s_nop;
    exec && cmd == dwd_pkg::cmd_nop;
  endsequence

  a_exec_at_end: assert property (!cs_s |=> !cmd_done && $stable(wiper_ch1) && $stable(wiper_ch2)) // RULE20
    else $error("command executed while chip select was low");

  a_nop_holds: assert property (s_nop |=> $stable(wiper_ch1) && $stable(wiper_ch2) && !rb_active) // RULE3
    else $error("no-op command changed a wiper");

  a_restore_copy: assert property (s_restore and !exec_ch |=> wiper_ch1 == $past(sel_nv_pos)) // RULE4
    else $error("restore did not copy the stored position");

  a_read_state: assert property (s_restore ##1 (!exec [*2]) |-> read_power_state [*1]) // RULE4
    else $error("read power state lost before a no-op");

  a_power_load: assert property (state == st_load |=> wiper_ch1 == $past(nv_pos[0]) && state == st_idle) // RULE19
    else $error("power-on load of wiper failed");

  a_inc_sat: assert property (exec && cmd == dwd_pkg::cmd_inc_all |=>
      wiper_ch1 == (($past(wiper_ch1) == W_FULL) ? W_FULL : $past(wiper_ch1) + W_ONE)) // RULE15
    else $error("ganged increment wrong");

  a_dec_sat: assert property (exec && cmd == dwd_pkg::cmd_dec_all |=>
      wiper_ch2 == (($past(wiper_ch2) == '0) ? '0 : $past(wiper_ch2) - W_ONE)) // RULE9
    else $error("ganged decrement wrong");

  a_shl_zero: assert property (exec && cmd == dwd_pkg::cmd_shl_all && wiper_ch1 == '0 |=> wiper_ch1 == W_ONE) // RULE22
    else $error("left shift of zero did not give one");

  a_shl_mid: assert property (exec && cmd == dwd_pkg::cmd_shl_all && wiper_ch1 >= W_MID |=> wiper_ch1 == W_FULL) // RULE23
    else $error("left shift at midscale did not saturate");

  a_write_wiper: assert property (exec && cmd == dwd_pkg::cmd_write_wiper && !exec_ch |=>
      wiper_ch1 == $past(exec_data[WIPER_W-1:0])) // RULE13
    else $error("wiper write lost data");

  a_read_arm: assert property (exec && cmd == dwd_pkg::cmd_read_wiper |=>
      rb_active && rb_data == {{PAD_W{1'b0}}, $past(sel_wiper)}) // RULE12
    else $error("wiper read-back not armed");

  a_rb_hold: assert property (rb_active && !frame_end |=> rb_active && $stable(rb_data)) // RULE17
    else $error("read-back value changed within a frame");
endmodule : dwd_decoder

//--- test/dwd_spi_master.sv
// serial controller model: sends command frames and captures the returned bits
`timescale 1ns/1ps
module dwd_spi_master (
  input wire logic pol,
  input wire logic serial_wire,
  output logic link_clk,
  output logic cs_n,
  output logic serial_in
);
  localparam time HALF = 24ns;
  logic [23:0] rx_word;
  event rx_ev;

  initial begin
    link_clk = 1'b1;
    cs_n = 1'b1;
    serial_in = 1'b1;
  end

  // clock stands at its idle level outside frames; the first 24 returned bits are kept
  task automatic send(input logic [47:0] w, input int nbits);
    logic [47:0] rx;
    rx = '0;
    link_clk = pol;
    #(HALF);
    cs_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      link_clk = 1'b0;
      serial_in = w[i];
      #(HALF);
      rx = {rx[46:0], serial_wire};
      link_clk = 1'b1;
      #(HALF);
    end
    link_clk = pol;
    #(HALF);
    // a strobe without clocks still has to be seen by the system clock
    if (nbits == 0) #(400ns);
    cs_n = 1'b1;
    serial_in = ~serial_in;
    if (nbits >= 24) rx_word = rx[nbits-1 -: 24];
    -> rx_ev;
    #(800ns);
  endtask : send
endmodule : dwd_spi_master

//--- test/tb_dual_wiper_serial_command_decoder.sv
// self-checking bench of the dual wiper command decoder against a serial controller model
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin bad_count++; \
  $display("FAIL %s expected %h seen %h", n, e, s); end end
module tb_dual_wiper_serial_command_decoder;
  localparam logic [15:0] USER_INIT = 16'h5a3c;
  localparam logic [15:0] TOL_INIT = 16'h0f0f;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b1;
  logic pol = 1'b1;
  logic link_clk, cs_n, serial_in, serial_out, serial_out_oe_n, read_power_state, cmd_done;
  logic [9:0] wiper_ch1, wiper_ch2;
  wire logic serial_wire;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [9:0] w [2];
  logic [15:0] nv [16];
  logic rps, rb_on;
  logic [23:0] prev;
  logic [15:0] rb;
  logic [20:0] exp_q[$];
  logic [24:0] rx_q[$];
  logic [20:0] ew;
  logic [24:0] er;
  logic [23:0] dir[$] = '{
    24'h0fa5c3,
    24'hb00000, 24'h600000, 24'hc00000, 24'h400000,
    24'hb1a3ff, 24'he1ffff, 24'hd00000, 24'hb10200, 24'hc10000,
    24'h21ffff, 24'hbf0123, 24'h800000, 24'hd00000, 24'h830000,
    24'h30fe01, 24'h120000, 24'h000000,
    24'h3e1234, 24'h9e0000, 24'ha10000, 24'h3fbeef, 24'h9f0000, 24'h000000,
    24'h5f0000, 24'h7a0000, 24'hff0000};

  always #50 sys_clk = ~sys_clk;
  // open-drain output with pull-up
  assign serial_wire = serial_out_oe_n ? 1'b1 : 1'b0;

  dwd_decoder #(.WIPER_W(10), .NV_USER_INIT(USER_INIT), .NV_TOLERANCE(TOL_INIT)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .link_clk(link_clk), .cs_n(cs_n), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n), .wiper_ch1(wiper_ch1),
    .wiper_ch2(wiper_ch2), .read_power_state(read_power_state), .cmd_done(cmd_done));

  dwd_spi_master m (.pol(pol), .serial_wire(serial_wire), .link_clk(link_clk), .cs_n(cs_n),
    .serial_in(serial_in));

  function automatic logic [9:0] shl(input logic [9:0] v);
    if (v == 10'h000) return 10'h001;
    if (v >= 10'h200) return 10'h3ff;
    return v << 1;
  endfunction : shl

  task automatic apply(input logic [23:0] f);
    logic [3:0] c;
    logic [3:0] a;
    c = f[23:20];
    a = f[19:16];
    for (int i = 0; i < 2; i++) begin
      if (i == int'(a[0]) || (c[0] && c[2]) || c == 4'h8) begin
        case (c)
          4'h1: w[i] = nv[i][9:0];
          4'h8: if (a == 4'h0) w[i] = nv[i][9:0];
          4'h2: nv[i] = {6'h00, w[i]};
          4'h4, 4'h5: w[i] = w[i] >> 1;
          4'h6, 4'h7: if (w[i] != 10'h000) w[i] = w[i] - 10'h001;
          4'ha: rb = {6'h00, w[i]};
          4'hb: w[i] = f[9:0];
          4'hc, 4'hd: w[i] = shl(w[i]);
          4'he, 4'hf: if (w[i] != 10'h3ff) w[i] = w[i] + 10'h001;
          default: ;
        endcase
      end
    end
    if (c == 4'h3 && a != 4'hf) nv[a] = f[15:0];
    if (c == 4'h9) rb = nv[a];
    rps = (c == 4'h1) ? 1'b1 : (c == 4'h0) ? 1'b0 : rps;
    rb_on = (c == 4'h9 || c == 4'ha);
    prev = f;
  endtask : apply

  task automatic frame(input logic [47:0] f, input int nb);
    rx_q.push_back({nb != 0, rb_on ? {prev[23:16], rb} : prev});
    // a strobe without clocks repeats the last executed command
    apply((nb == 0) ? prev : f[23:0]);
    exp_q.push_back({rps, w[1], w[0]});
    m.send(f, nb);
  endtask : frame

  task automatic do_reset();
    @(negedge sys_clk);
    reset_n = 1'b0;
    // power-on brings the stores back to their initial content
    for (int i = 0; i < 16; i++) nv[i] = (i < 2) ? 16'h0200 : (i == 15) ? TOL_INIT : USER_INIT;
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    for (int i = 0; i < 2; i++) w[i] = nv[i][9:0];
    rps = 1'b0;
    rb_on = 1'b0;
    prev = 24'h000000;
    repeat (3) @(negedge sys_clk);
  endtask : do_reset

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 20000) begin
      bad_count++;
      end_sim();
    end else if (cmd_done === 1'b1) begin
      `CHK("done outside frame", 1'b1, cs_n)
      if (exp_q.size() == 0) `CHK("unexpected done", 1'b0, cmd_done)
      else begin
        ew = exp_q.pop_front();
        `CHK("wipers", ew, {read_power_state, wiper_ch2, wiper_ch1})
      end
    end
  end

  always begin
    @(m.rx_ev);
    er = rx_q.pop_front();
    if (er[24]) `CHK("serial out", er[23:0], m.rx_word)
  end

  initial begin
    logic [3:0] c;
    logic [3:0] a;
    void'($urandom(32'ha97b));
    do_reset();
    foreach (dir[k]) frame({24'h000000, dir[k]}, 24);
    frame(48'h0, 0);
    do_reset();
    frame({28'h0000000, 4'h0, 16'($urandom)}, 24);
    pol = 1'b0;
    for (int k = 0; k < 40; k++) begin
      c = 4'($urandom_range(15));
      a = 4'($urandom_range(15));
      if (c == 4'h8) a = 4'h0;
      if (c == 4'h3 && a == 4'hf) a = 4'he;
      frame({24'h000000, c, a, 16'($urandom)}, 24);
    end
    frame(48'h0, 24);
    frame({24'hb00155, 24'hb102aa}, 48);
    frame(48'h0, 24);
    repeat (10) @(negedge sys_clk);
    `CHK("pending results", 0, exp_q.size())
    end_sim();
  end
endmodule : tb_dual_wiper_serial_command_decoder
